// [rtl/amc_defs.svh]
`ifndef AMC_DEFS_SVH
`define AMC_DEFS_SVH
// ==========================================
// Mode register reset value
`define AMC_MODE_RESET 16'h000a
// ==========================================
// Operating mode codes
`define AMC_MD_CONT 3'h0
`define AMC_MD_SINGLE 3'h1
`define AMC_MD_IDLE 3'h2
`define AMC_MD_PDOWN 3'h3
// ==========================================
// Clock source codes
`define AMC_CS_INT 2'h0
`define AMC_CS_INT_OUT 2'h1
`define AMC_CS_EXT 2'h2
`define AMC_CS_EXT_DIV2 2'h3
// ==========================================
// Register select codes and serial frame lengths
`define AMC_RS_STATUS 3'h0
`define AMC_RS_MODE 3'h1
`define AMC_RS_DATA 3'h3
`define AMC_CMD_LAST 6'h07
`define AMC_STATUS_LEN 6'h08
`define AMC_SETUP_LEN 6'h10
// ==========================================
// Timing
`define AMC_CLK_HZ 100000000
`define AMC_OSC_HZ 64000
`define AMC_OSC_HALF_CYC ((`AMC_CLK_HZ / `AMC_OSC_HZ) / 2)
`define AMC_TICKS_PER_MS (`AMC_OSC_HZ / 1000)
`define AMC_SETTLE_US 1000
`define AMC_SETTLE_CYC (`AMC_SETTLE_US * (`AMC_CLK_HZ / 1000000))
`endif

// [rtl/amc_pkg.sv]
// ==========================================
// Shared types
package amc_pkg;
   // Mode register layout, most significant field first
   typedef struct packed {
      logic [2:0] operating_mode_select;
      logic [4:0] reserved_zero;
      logic clock_source_select_hi;
      logic clock_source_select_lo;
      logic mode_bit_five;
      logic mode_bit_four;
      logic [3:0] update_rate_select;
   } amc_mode_t;
   // Conversion sequencer states
   typedef enum logic [2:0] {SQ_OFF, SQ_SETTLE, SQ_CONV, SQ_HOLD, SQ_IDLE} amc_seq_t;
   // Serial port states
   typedef enum logic [1:0] {SP_CMD, SP_WR, SP_RD, SP_CREAD} amc_sp_t;
   // Decoded command byte
   typedef struct packed {
      logic rd;
      logic [2:0] sel;
      logic cread;
   } amc_cmd_t;
endpackage : amc_pkg

// [rtl/amc_buffer.sv]
`timescale 1ns/1ns
// ==========================================
// Result buffer with valid and ready on both sides
module amc_buffer #(
   parameter int W = 24,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   generate
      if (DEPTH < 2 || (1 << PW) != DEPTH)
      begin : g_bad_depth
         $error("DEPTH must be a power of two of at least 2");
      end
   endgenerate
   logic [W-1:0] mem [DEPTH]; // Storage
   logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [PW:0] count, next_count; // Words held
   logic push, pop;

   // ==========================================
   // Pointer and count update
   always_comb
   begin
      in_ready = count != (PW+1)'(DEPTH);
      out_valid = count != '0;
      out_data = mem[rd_ptr];
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + (PW+1)'(push) - (PW+1)'(pop);
   end

   // Registers
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // Stalled head word stays put
   a_head_stable: assert property (@(posedge clk) disable iff (!resetn)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("head word changed under stall");
   // Count never exceeds depth
   a_count_bound: assert property (@(posedge clk) disable iff (!resetn)
      count <= (PW+1)'(DEPTH))
      else $error("buffer overfilled");
endmodule : amc_buffer

// [rtl/amc_top.sv]
`timescale 1ns/1ns
`include "amc_defs.svh"
// ==========================================
// Operation
// R1: Source 00: internal clock, pin not driven
// R2: Source 01: internal clock, driven on pin
// R3: Source 10: external clock used directly
// R4: Source 11: external clock divided by two
// R5: Host writes zeros to mode bits five, four
// R6: Mode 000: back-to-back conversions, ready low
// R7: Continuous read shifts results without command
// R8: Otherwise a read command fetches result
// R9: First conversion two periods after restart
// R10: Single: 1 ms settle, then two periods
// R11: Single end: store, ready low, power-down
// R12: Single result and ready held until read
// R13: Idle holds filter, modulator clock continues
// R14: Ready clears on load, sets on read
// R15: Setup write resets filter, sets not-ready; results converted before it still load and drive ready low
// R16: Mode 011 powers down, clock output off
module amc_top #(
   parameter int DATA_W = 24,
   parameter int BUF_DEPTH = 2,
   parameter int SETTLE_CYC = `AMC_SETTLE_CYC
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // Serial port
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic DIN,
   output logic DOUT,
   // Clock pin, three signals
   input wire logic CLK_PIN_IN,
   output logic CLK_PIN_OUT,
   output logic CLK_PIN_OE_N,
   // Modulator and filter
   input wire logic [DATA_W-1:0] RESULT_IN,
   output logic FILTER_RST,
   output logic MOD_CLK_TICK,
   // Status
   output logic RDY_N
);
   import amc_pkg::*;

   localparam logic [10:0] OSC_HALF = 11'(`AMC_OSC_HALF_CYC - 1);
   localparam int SW = $clog2(SETTLE_CYC + 1);
   localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYC - 1);
   localparam logic [5:0] DATA_LEN = 6'(DATA_W);

   generate
      if (DATA_W < 16 || DATA_W > 32)
      begin : g_bad_width
         $error("DATA_W must lie between 16 and 32");
      end
      if (SETTLE_CYC < 1)
      begin : g_bad_settle
         $error("SETTLE_CYC must be at least 1");
      end
   endgenerate

   // ==========================================
   // Declarations
   amc_mode_t mode_reg, next_mode_reg; // Mode register
   logic [1:0] clk_src; // Clock source field
   logic powered; // Not in power-down
   logic [10:0] osc_cnt, next_osc_cnt; // Oscillator half-period count
   logic osc_lvl, next_osc_lvl; // Oscillator level
   logic ext_prev, next_ext_prev; // Clock pin last sample
   logic div_ph, next_div_ph; // Divide-by-two phase
   logic next_clk_out, next_clk_oe_n, next_mod_tick;
   logic ext_rise, osc_rise, conv_tick; // Conversion clock events
   amc_seq_t seq, next_seq; // Sequencer state
   logic [15:0] tick_cnt, next_tick_cnt; // Conversion clock count
   logic [SW-1:0] settle_cnt, next_settle_cnt; // Oscillator settle count
   logic first, next_first; // First conversion after restart
   logic restart, next_restart; // Registered setup write
   logic [DATA_W-1:0] res_hold, next_res_hold; // Finished result
   logic next_filter_rst;
   logic [15:0] period, target; // Ticks per update period, per conversion
   logic single, single_done;
   amc_sp_t sp, next_sp; // Serial state
   amc_cmd_t cmd, next_cmd; // Latched command
   logic sclk_prev, next_sclk_prev;
   logic [5:0] bit_cnt, next_bit_cnt, word_len;
   logic [15:0] shift_in, next_shift_in;
   logic [DATA_W-1:0] shift_out, next_shift_out, rd_word, next_rd_word, out_src;
   logic [7:0] cmd_byte;
   logic next_dout, setup_wr, data_rd, sclk_rise, sclk_fall;
   logic [DATA_W-1:0] data_reg, next_data_reg, buf_out_data; // Data register
   logic ld_pend, next_ld_pend, next_rdy_n, data_busy;
   logic buf_in_ready, buf_out_valid;

   // Update period in conversion clock ticks, half the tabled time in ms
   function automatic logic [15:0] period_ticks(input logic [3:0] fs);
      logic [8:0] ms;
      unique case (fs)
         4'h0: ms = 9'h000;
         4'h1: ms = 9'h004;
         4'h2: ms = 9'h008;
         4'h3: ms = 9'h010;
         4'h4: ms = 9'h020;
         4'h5: ms = 9'h028;
         4'h6: ms = 9'h030;
         4'h7: ms = 9'h03c;
         4'h8: ms = 9'h065;
         4'h9: ms = 9'h078;
         4'ha: ms = 9'h078;
         4'hb: ms = 9'h0a0;
         4'hc: ms = 9'h0c8;
         4'hd: ms = 9'h0f0;
         4'he: ms = 9'h140;
         4'hf: ms = 9'h1e0;
      endcase
      return 16'((32'(ms) * `AMC_TICKS_PER_MS) / 2);
   endfunction : period_ticks

   // ==========================================
   // Conversion clock and clock pin
   always_comb
   begin
      clk_src = {mode_reg.clock_source_select_hi, mode_reg.clock_source_select_lo};
      powered = mode_reg.operating_mode_select != `AMC_MD_PDOWN; // [R16]
      ext_rise = CLK_PIN_IN & ~ext_prev;
      osc_rise = powered & (osc_cnt == OSC_HALF) & ~osc_lvl;
      next_ext_prev = CLK_PIN_IN;
      next_div_ph = div_ph;
      next_osc_cnt = osc_cnt + 11'h001;
      next_osc_lvl = osc_lvl;
      // Oscillator stops in power-down
      if (!powered)
      begin
         next_osc_cnt = 11'h000;
         next_osc_lvl = 1'b0;
      end
      else if (osc_cnt == OSC_HALF)
      begin
         next_osc_cnt = 11'h000;
         next_osc_lvl = ~osc_lvl;
      end
      // Pick the conversion clock source
      unique case (clk_src)
         `AMC_CS_INT, `AMC_CS_INT_OUT: conv_tick = osc_rise; // [R1] [R2]
         `AMC_CS_EXT: conv_tick = powered & ext_rise; // [R3]
         `AMC_CS_EXT_DIV2:
         begin
            conv_tick = powered & ext_rise & div_ph; // [R4]
            if (powered & ext_rise)
               next_div_ph = ~div_ph;
         end
      endcase
      // Pin driven only for the output-enabled internal source
      next_clk_oe_n = ~(powered & (clk_src == `AMC_CS_INT_OUT)); // [R1] [R2] [R16]
      next_clk_out = ~next_clk_oe_n & next_osc_lvl;
      // Modulator clock runs in idle too
      next_mod_tick = conv_tick; // [R13]
   end

   // Registers
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         osc_cnt <= 11'h000;
         osc_lvl <= 1'b0;
         ext_prev <= 1'b0;
         div_ph <= 1'b0;
         CLK_PIN_OUT <= 1'b0;
         CLK_PIN_OE_N <= 1'b1;
         MOD_CLK_TICK <= 1'b0;
      end
      else
      begin
         osc_cnt <= next_osc_cnt;
         osc_lvl <= next_osc_lvl;
         ext_prev <= next_ext_prev;
         div_ph <= next_div_ph;
         CLK_PIN_OUT <= next_clk_out;
         CLK_PIN_OE_N <= next_clk_oe_n;
         MOD_CLK_TICK <= next_mod_tick;
      end
   end

   // ==========================================
   // Conversion sequencer
   always_comb
   begin
      single = mode_reg.operating_mode_select == `AMC_MD_SINGLE;
      period = period_ticks(mode_reg.update_rate_select);
      // Two periods for the first or single conversion
      target = (first | single) ? {period[14:0], 1'b0} : period; // [R9] [R10]
      next_seq = seq;
      next_tick_cnt = tick_cnt;
      next_settle_cnt = settle_cnt;
      next_first = first;
      next_res_hold = res_hold;
      next_restart = setup_wr;
      single_done = 1'b0;
      if (restart)
      begin
         // Any setup write starts over from the new mode
         next_tick_cnt = 16'h0000;
         next_settle_cnt = '0;
         next_first = 1'b1; // [R9]
         unique case (mode_reg.operating_mode_select)
            `AMC_MD_CONT: next_seq = SQ_CONV; // [R6]
            `AMC_MD_SINGLE: next_seq = SQ_SETTLE; // [R10]
            `AMC_MD_PDOWN: next_seq = SQ_OFF; // [R16]
            default: next_seq = SQ_IDLE; // [R13]
         endcase
      end
      else
      begin
         unique case (seq)
            // Oscillator power-up wait
            SQ_SETTLE:
            begin
               if (settle_cnt == SETTLE_LAST) // [R10]
               begin
                  next_seq = SQ_CONV;
                  next_tick_cnt = 16'h0000;
               end
               else
                  next_settle_cnt = settle_cnt + 1'b1;
            end
            // Count conversion clock ticks
            SQ_CONV:
            begin
               if (conv_tick & (period != 16'h0000))
               begin
                  if (tick_cnt == target - 16'h0001) // [R9]
                  begin
                     next_seq = SQ_HOLD;
                     next_res_hold = RESULT_IN;
                  end
                  else
                     next_tick_cnt = tick_cnt + 16'h0001;
               end
            end
            // Wait for buffer room; conversion stalls meanwhile
            SQ_HOLD:
            begin
               if (buf_in_ready)
               begin
                  next_tick_cnt = 16'h0000;
                  if (single)
                  begin
                     next_seq = SQ_OFF; // [R11]
                     single_done = 1'b1;
                  end
                  else
                  begin
                     next_seq = SQ_CONV; // [R6]
                     next_first = 1'b0;
                  end
               end
            end
            SQ_OFF, SQ_IDLE: next_seq = seq;
         endcase
      end
      // Filter held in reset when not converting
      next_filter_rst = next_restart | (next_seq == SQ_IDLE) | (next_seq == SQ_OFF)
         | (next_seq == SQ_SETTLE); // [R13] [R15]
   end

   // Registers
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         seq <= SQ_CONV;
         tick_cnt <= 16'h0000;
         settle_cnt <= '0;
         first <= 1'b1;
         restart <= 1'b0;
         res_hold <= '0;
         FILTER_RST <= 1'b1;
      end
      else
      begin
         seq <= next_seq;
         tick_cnt <= next_tick_cnt;
         settle_cnt <= next_settle_cnt;
         first <= next_first;
         restart <= next_restart;
         res_hold <= next_res_hold;
         FILTER_RST <= next_filter_rst;
      end
   end

   // ==========================================
   // Serial port and mode register
   always_comb
   begin
      sclk_rise = SCLK & ~sclk_prev;
      sclk_fall = ~SCLK & sclk_prev;
      next_sclk_prev = SCLK;
      cmd_byte = {shift_in[6:0], DIN};
      word_len = (cmd.sel == `AMC_RS_STATUS) ? `AMC_STATUS_LEN
         : (cmd.sel == `AMC_RS_DATA) ? DATA_LEN : `AMC_SETUP_LEN;
      // First bit of a word comes from the snapshot or live data
      out_src = (bit_cnt == 6'h00) ? ((sp == SP_CREAD) ? data_reg : rd_word) : shift_out;
      next_sp = sp;
      next_cmd = cmd;
      next_bit_cnt = bit_cnt;
      next_shift_in = shift_in;
      next_shift_out = shift_out;
      next_rd_word = rd_word;
      next_dout = DOUT;
      setup_wr = 1'b0;
      data_rd = 1'b0;
      next_mode_reg = mode_reg;
      if (single_done)
         next_mode_reg.operating_mode_select = `AMC_MD_PDOWN; // [R11]
      if (CS_N)
      begin
         // Deselect ends any frame and continuous read
         next_sp = SP_CMD;
         next_bit_cnt = 6'h00;
         next_dout = 1'b1;
      end
      else
      begin
         // Output changes on the falling edge
         if (sclk_fall)
         begin
            if (sp == SP_RD || sp == SP_CREAD)
            begin
               next_dout = out_src[DATA_W-1]; // [R7] [R8]
               next_shift_out = out_src << 1;
            end
            else
               next_dout = RDY_N;
         end
         // Input taken on the rising edge
         if (sclk_rise)
         begin
            next_shift_in = {shift_in[14:0], DIN};
            next_bit_cnt = bit_cnt + 6'h01;
            unique case (sp)
               SP_CMD:
               begin
                  if (bit_cnt == `AMC_CMD_LAST)
                  begin
                     next_bit_cnt = 6'h00;
                     next_cmd = '{rd: cmd_byte[6], sel: cmd_byte[5:3], cread: cmd_byte[2]};
                     unique case (cmd_byte[5:3])
                        `AMC_RS_STATUS: next_rd_word = DATA_W'({RDY_N, 7'h00}) << (DATA_W - 8);
                        `AMC_RS_MODE: next_rd_word = DATA_W'(mode_reg) << (DATA_W - 16);
                        `AMC_RS_DATA: next_rd_word = data_reg;
                        default: next_rd_word = '0;
                     endcase
                     if (cmd_byte[7])
                        next_sp = SP_CMD;
                     else if (!cmd_byte[6])
                        next_sp = SP_WR;
                     else if (cmd_byte[2] && cmd_byte[5:3] == `AMC_RS_DATA)
                        next_sp = SP_CREAD; // [R7]
                     else
                        next_sp = SP_RD; // [R8]
                  end
               end
               SP_WR:
               begin
                  if (bit_cnt == word_len - 6'h01)
                  begin
                     next_sp = SP_CMD;
                     next_bit_cnt = 6'h00;
                     setup_wr = cmd.sel != `AMC_RS_STATUS && cmd.sel != `AMC_RS_DATA; // [R15]
                     if (cmd.sel == `AMC_RS_MODE)
                        next_mode_reg = amc_mode_t'(next_shift_in);
                  end
               end
               SP_RD:
               begin
                  if (bit_cnt == word_len - 6'h01)
                  begin
                     next_sp = SP_CMD;
                     next_bit_cnt = 6'h00;
                     data_rd = cmd.sel == `AMC_RS_DATA; // [R8] [R14]
                  end
               end
               SP_CREAD:
               begin
                  if (bit_cnt == DATA_LEN - 6'h01)
                  begin
                     next_bit_cnt = 6'h00;
                     data_rd = 1'b1; // [R7] [R14]
                  end
               end
            endcase
         end
      end
   end

   // Registers
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         sp <= SP_CMD;
         cmd <= '0;
         sclk_prev <= 1'b1;
         bit_cnt <= 6'h00;
         shift_in <= 16'h0000;
         shift_out <= '0;
         rd_word <= '0;
         DOUT <= 1'b1;
         mode_reg <= amc_mode_t'(`AMC_MODE_RESET);
      end
      else
      begin
         sp <= next_sp;
         cmd <= next_cmd;
         sclk_prev <= next_sclk_prev;
         bit_cnt <= next_bit_cnt;
         shift_in <= next_shift_in;
         shift_out <= next_shift_out;
         rd_word <= next_rd_word;
         DOUT <= next_dout;
         mode_reg <= next_mode_reg;
      end
   end

   // ==========================================
   // Result buffer and data register
   amc_buffer #(.W(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
      .clk(CLK),
      .resetn(RESETN),
      .in_valid(seq == SQ_HOLD),
      .in_ready(buf_in_ready),
      .in_data(res_hold),
      .out_valid(buf_out_valid),
      .out_ready(ld_pend),
      .out_data(buf_out_data)
   );

   // Load stage raises not-ready one cycle before the update
   always_comb
   begin
      data_busy = (sp == SP_RD && cmd.sel == `AMC_RS_DATA)
         || (sp == SP_CREAD && bit_cnt != 6'h00);
      next_ld_pend = buf_out_valid & ~data_busy & ~ld_pend;
      next_data_reg = ld_pend ? buf_out_data : data_reg;
      next_rdy_n = RDY_N; // [R12]
      if (data_rd | setup_wr | next_ld_pend)
         next_rdy_n = 1'b1; // [R14] [R15]
      if (ld_pend)
         next_rdy_n = 1'b0; // [R6] [R11] [R14]
   end

   // Registers
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         ld_pend <= 1'b0;
         data_reg <= '0;
         RDY_N <= 1'b1;
      end
      else
      begin
         ld_pend <= next_ld_pend;
         data_reg <= next_data_reg;
         RDY_N <= next_rdy_n;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   a_clk_pin_off: assert property (clk_src != `AMC_CS_INT_OUT |=> CLK_PIN_OE_N) // [R1]
      else $error("clock pin driven for wrong source");
   a_clk_pin_drive: assert property (powered && clk_src == `AMC_CS_INT_OUT // [R2]
      |=> !CLK_PIN_OE_N && CLK_PIN_OUT == osc_lvl)
      else $error("clock pin not carrying oscillator");
   a_ext_tick: assert property (powered && clk_src == `AMC_CS_EXT && ext_rise // [R3]
      |=> MOD_CLK_TICK)
      else $error("external edge gave no tick");
   a_div_two: assert property (powered && clk_src == `AMC_CS_EXT_DIV2 && ext_rise // [R4]
      && !div_ph |-> !conv_tick ##1 div_ph)
      else $error("divide by two phase wrong");
   a_cont_next: assert property (seq == SQ_HOLD && buf_in_ready && !restart && !single // [R6]
      |=> seq == SQ_CONV && tick_cnt == 16'h0000 && !first)
      else $error("continuous conversion did not restart");
   a_cread_out: assert property (!CS_N && sp == SP_CREAD && sclk_fall // [R7]
      && bit_cnt == 6'h00 |=> DOUT == $past(data_reg[DATA_W-1]))
      else $error("continuous read first bit wrong");
   a_first_conv: assert property (restart && mode_reg.operating_mode_select == `AMC_MD_CONT // [R9]
      |=> seq == SQ_CONV && first && tick_cnt == 16'h0000)
      else $error("restart did not begin a two period conversion");
   a_settle_end: assert property (seq == SQ_SETTLE && !restart && settle_cnt == SETTLE_LAST // [R10]
      |=> seq == SQ_CONV && tick_cnt == 16'h0000)
      else $error("settle wait did not end");
   a_single_pd: assert property (single_done && !setup_wr // [R11]
      |=> seq == SQ_OFF && mode_reg.operating_mode_select == `AMC_MD_PDOWN)
      else $error("single conversion did not power down");
   a_ready_hold: assert property (!RDY_N && !data_rd && !setup_wr && !next_ld_pend // [R12]
      |=> !RDY_N)
      else $error("ready dropped without cause");
   a_idle_rst: assert property (seq == SQ_IDLE && !restart |=> FILTER_RST) // [R13]
      else $error("idle left filter running");
   a_load_ready: assert property (ld_pend // [R14]
      |=> !RDY_N && data_reg == $past(buf_out_data))
      else $error("load did not show ready");
   a_setup_rst: assert property (setup_wr && !ld_pend |=> FILTER_RST && RDY_N) // [R15]
      else $error("setup write did not reset");
   a_pd_quiet: assert property (!powered |=> CLK_PIN_OE_N && !MOD_CLK_TICK) // [R16]
      else $error("power-down left clocks running");
endmodule : amc_top

// [dv/amc_host_model.sv]
`timescale 1ns/1ns
// ==========================================
// Host model on the serial port
module amc_host_model (
   // Clock
   input wire logic clk,
   // Serial port
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   // Idle: deselected, clock high
   initial
   begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b1;
   end
   // One frame, MSB first, DOUT taken at each rise
   task automatic frame(input int n, input logic [39:0] wv, output logic [39:0] rv);
      rv = '0;
      @(posedge clk) cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         @(posedge clk) sclk <= 1'b0;
         din <= wv[i];
         repeat (3) @(posedge clk);
         sclk <= 1'b1;
         repeat (3) @(posedge clk);
         rv[i] = dout;
      end
      // Released line shows the inverse of its last value
      @(posedge clk) cs_n <= 1'b1;
      din <= ~din;
   endtask : frame
endmodule : amc_host_model

// [dv/adc_mode_and_clock_control_tb_top.sv]
`timescale 1ns/1ns
module adc_mode_and_clock_control_tb_top;
   import amc_pkg::*;
   logic clk, resetn, sclk, cs_n, din, dout, pin_out, oe_n, frst, tick, rdy_n;
   logic ext_clk = 1'b0;
   logic [23:0] result = 24'h5a3c96;
   logic [39:0] rv;
   int fail_count = 0, n_compared = 0, cyc = 0, n;
   amc_top #(.SETTLE_CYC(20)) i_amc_top (.CLK(clk), .RESETN(resetn), .SCLK(sclk),
      .CS_N(cs_n), .DIN(din), .DOUT(dout), .CLK_PIN_IN(ext_clk), .CLK_PIN_OUT(pin_out),
      .CLK_PIN_OE_N(oe_n), .RESULT_IN(result), .FILTER_RST(frst), .MOD_CLK_TICK(tick),
      .RDY_N(rdy_n));
   amc_host_model i_amc_host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // External clock of 8 cycles, supplied by us hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      ext_clk <= cyc[2];
      if (cyc == 60000)
      begin
         fail_count++;
         finish_test();
      end
   end
   task automatic check(input string s, input logic [39:0] seen, input logic [39:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", s, exp, seen);
      end
   endtask : check
   // Mode write; bits five and four always zero
   task automatic wr(input logic [15:0] m);
      i_amc_host_model.frame(24, {16'h0000, 8'h08, m}, rv);
   endtask : wr
   task automatic rd(input logic [7:0] c, input int w);
      i_amc_host_model.frame(w + 8, {c, 32'h00000000} >> (32 - w), rv);
   endtask : rd
   task automatic wait_rdy();
      n = 0;
      while (rdy_n !== 1'b0 && n < 9000)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_rdy
   task automatic t_reset();
      check("ready", rdy_n, 1'b1);
      rd(8'h48, 16);
      check("mode", rv[15:0], 16'h000a);
      $display("reset test done");
   endtask : t_reset
   task automatic t_cont();
      wr(16'h0081);
      check("ready", rdy_n, 1'b1);
      check("frst", frst, 1'b0);
      wait_rdy();
      check("first", n >= 2020 && n <= 2080, 1'b1);
      rd(8'h58, 24);
      check("data", rv[23:0], 24'h5a3c96);
      check("ready", rdy_n, 1'b1);
      result <= 24'hc3e10f;
      wait_rdy();
      rd(8'h5c, 24);
      check("cread", rv[23:0], 24'hc3e10f);
      $display("continuous test done");
   endtask : t_cont
   task automatic t_modes();
      wr(16'h4041);
      check("oe", oe_n, 1'b0);
      check("frst", frst, 1'b1);
      n = 0;
      while (tick !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      check("tick", tick, 1'b1);
      check("pin", pin_out, 1'b1);
      wr(16'h4001);
      check("oe", oe_n, 1'b1);
      check("pin", pin_out, 1'b0);
      wr(16'h6041);
      check("oe", oe_n, 1'b1);
      check("pin", pin_out, 1'b0);
      repeat (2000)
      begin
         @(posedge clk);
         if (tick !== 1'b0)
            check("pd tick", tick, 1'b0);
      end
      $display("mode test done");
   endtask : t_modes
   task automatic t_div2();
      wr(16'h00c1);
      wait_rdy();
      check("div2", n >= 4060 && n <= 4140, 1'b1);
      $display("divide test done");
   endtask : t_div2
   task automatic t_single();
      result <= 24'h0f1e2d;
      wr(16'h2081);
      check("ready", rdy_n, 1'b1);
      wait_rdy();
      check("single", n >= 2040 && n <= 2110, 1'b1);
      rd(8'h48, 16);
      check("mode", rv[15:0], 16'h6081);
      check("ready", rdy_n, 1'b0);
      rd(8'h40, 8);
      check("status", rv[7:0], 8'h00);
      rd(8'h58, 24);
      check("data", rv[23:0], 24'h0f1e2d);
      $display("single test done");
   endtask : t_single
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   initial
   begin
      resetn = 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_cont();
      t_modes();
      t_div2();
      t_single();
      finish_test();
   end
endmodule : adc_mode_and_clock_control_tb_top
